// ### src/break_pkg.sv
// Purpose: Shared constants and types for the two-channel break condition matcher.
// Assumes: 16-bit registers on a plain strobe port, one word per offset.
// Notes:   Channel B registers sit one stride above channel A.
package break_pkg;
  localparam int NUM_CH  = 2;
  localparam int ADDR_W  = 8;
  localparam int HALF_W  = 16;
  localparam int BADDR_W = 32;
  localparam int CYC_W   = 8;

  localparam logic [7:0] CH_STRIDE    = 8'h08;
  localparam logic [7:0] OFS_ADDR_HI  = 8'h00;
  localparam logic [7:0] OFS_ADDR_LO  = 8'h01;
  localparam logic [7:0] OFS_MASK_HI  = 8'h02;
  localparam logic [7:0] OFS_MASK_LO  = 8'h03;
  localparam logic [7:0] OFS_CYC_SEL  = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h11;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h12;

  localparam logic [15:0] HALF_RST = 16'h0000;
  localparam logic [7:0]  CYC_RST  = 8'h00;

  localparam int EXT_EN_BIT = 0;
  localparam int MSEL_HI    = 7;
  localparam int MSEL_LO    = 6;
  localparam int FSEL_HI    = 5;
  localparam int FSEL_LO    = 4;
  localparam int DSEL_HI    = 3;
  localparam int DSEL_LO    = 2;
  localparam int SSEL_HI    = 1;
  localparam int SSEL_LO    = 0;

  typedef enum logic [1:0] {
    MASTER_CPU = 2'h0,
    MASTER_DMA = 2'h1,
    MASTER_EXT = 2'h2
  } master_t;

  typedef enum logic [1:0] {
    SIZE_ANY  = 2'h0,
    SIZE_BYTE = 2'h1,
    SIZE_WORD = 2'h2,
    SIZE_LONG = 2'h3
  } size_t;
endpackage : break_pkg

// ### src/chan_if.sv
// Purpose: Carries one channel's settings and the watched bus cycle to its matcher.
// Assumes: All signals live on the system clock.
// Notes:   The match result is combinational; the top registers it.
`timescale 1ns/1ps
interface chan_if;
  import break_pkg::*;
  logic [BADDR_W-1:0] brk_addr;
  logic [BADDR_W-1:0] addr_mask;
  logic [CYC_W-1:0]   cyc_sel;
  logic               ext_en;
  logic               bus_valid;
  logic [BADDR_W-1:0] bus_addr;
  master_t            bus_master;
  logic               bus_fetch;
  logic               bus_write;
  size_t              bus_size;
  logic               match;
  modport cfg (output brk_addr, addr_mask, cyc_sel, ext_en, bus_valid, bus_addr,
               bus_master, bus_fetch, bus_write, bus_size, input match);
  modport chk (input brk_addr, addr_mask, cyc_sel, ext_en, bus_valid, bus_addr,
               bus_master, bus_fetch, bus_write, bus_size, output match);
endinterface : chan_if

// ### src/break_channel.sv
// Purpose: Decides whether one bus cycle meets one channel's break condition.
// Assumes: Bus fields are stable for the cycle in which bus_valid is high.
// Notes:   Pure combinational; no state.
`timescale 1ns/1ps
module break_channel (
  chan_if.chk chan
);
  import break_pkg::*;

  logic  is_cpu;
  logic  is_periph;
  logic  master_ok;
  logic  kind_ok;
  logic  dir_ok;
  logic  size_ok;
  logic  addr_ok;
  size_t eff_size;

  assign is_cpu    = (chan.bus_master == MASTER_CPU);
  // DMA always counts as peripheral; a released-bus master only when enabled.
  assign is_periph = (chan.bus_master == MASTER_DMA) ||
                     ((chan.bus_master == MASTER_EXT) && chan.ext_en);
  assign master_ok = (chan.cyc_sel[MSEL_LO] && is_cpu) ||
                     (chan.cyc_sel[MSEL_HI] && is_periph);
  assign kind_ok   = (chan.cyc_sel[FSEL_LO] && chan.bus_fetch) ||
                     (chan.cyc_sel[FSEL_HI] && !chan.bus_fetch);
  assign dir_ok    = (chan.cyc_sel[DSEL_LO] && !chan.bus_write) ||
                     (chan.cyc_sel[DSEL_HI] && chan.bus_write);
  // The bus fetch itself is a longword, but each instruction counts as a word.
  assign eff_size  = chan.bus_fetch ? SIZE_WORD : chan.bus_size;
  assign size_ok   = (chan.cyc_sel[SSEL_HI:SSEL_LO] == SIZE_ANY) ||
                     (chan.cyc_sel[SSEL_HI:SSEL_LO] == eff_size);
  // A set mask bit removes that address bit from the comparison.
  assign addr_ok   = (((chan.bus_addr ^ chan.brk_addr) & ~chan.addr_mask)
                      == {BADDR_W{1'b0}});
  assign chan.match = chan.bus_valid && addr_ok && master_ok &&
                      kind_ok && dir_ok && size_ok;
endmodule : break_channel

// ### src/break_condition_matcher.sv
// Purpose: Two-channel break condition matcher with register port and interrupt.
// Assumes: Monitored bus fields come from logic on the same clock.
// Notes:   Reset acts as a power-on reset; it wins over the clock enable.
`timescale 1ns/1ps
module break_condition_matcher (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_clk_en,
  input  wire logic [break_pkg::ADDR_W-1:0] i_reg_addr,
  input  wire logic [break_pkg::HALF_W-1:0] i_reg_wdata,
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  output logic      [break_pkg::HALF_W-1:0] o_reg_rdata,
  input  wire logic                         i_bus_valid,
  input  wire logic [break_pkg::BADDR_W-1:0] i_bus_addr,
  input  wire break_pkg::master_t           i_bus_master,
  input  wire logic                         i_bus_fetch,
  input  wire logic                         i_bus_write,
  input  wire break_pkg::size_t             i_bus_size,
  output logic      [break_pkg::NUM_CH-1:0] o_break,
  output logic                              o_irq
);
  import break_pkg::*;

  // Bit ranges of the upper and lower 16-bit halves of an address or mask word.
  localparam int HI_MSB = BADDR_W - 1;
  localparam int HI_LSB = HALF_W;
  localparam int LO_MSB = HALF_W - 1;
  localparam int LO_LSB = 0;

  logic [BADDR_W-1:0] brk_addr_r  [NUM_CH];
  logic [BADDR_W-1:0] addr_mask_r [NUM_CH];
  logic [CYC_W-1:0]   cyc_sel_r   [NUM_CH];
  logic [NUM_CH-1:0]  match;
  logic [NUM_CH-1:0]  break_r;
  logic [NUM_CH-1:0]  irq_stat_r;
  logic [NUM_CH-1:0]  irq_stat_nxt;
  logic [NUM_CH-1:0]  irq_mask_r;
  logic [NUM_CH-1:0]  stat_clr;
  logic               ext_en_r;
  logic               irq_r;
  logic [HALF_W-1:0]  rdata_r;
  logic [HALF_W-1:0]  rdata_nxt;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : gen_ch
      localparam logic [7:0] BASE = CH_STRIDE * 8'(ch);
      logic wr_addr_hi;
      logic wr_addr_lo;
      logic wr_mask_hi;
      logic wr_mask_lo;
      logic wr_cyc;

      always_comb begin
        wr_addr_hi = 1'b0;
        wr_addr_lo = 1'b0;
        wr_mask_hi = 1'b0;
        wr_mask_lo = 1'b0;
        wr_cyc     = 1'b0;
        if (!i_reg_wr) begin
          wr_cyc = 1'b0;
        end else if (i_reg_addr == BASE + OFS_ADDR_HI) begin
          wr_addr_hi = 1'b1;
        end else if (i_reg_addr == BASE + OFS_ADDR_LO) begin
          wr_addr_lo = 1'b1;
        end else if (i_reg_addr == BASE + OFS_MASK_HI) begin
          wr_mask_hi = 1'b1;
        end else if (i_reg_addr == BASE + OFS_MASK_LO) begin
          wr_mask_lo = 1'b1;
        end else if (i_reg_addr == BASE + OFS_CYC_SEL) begin
          wr_cyc = 1'b1;
        end
      end

      // Channel B keeps the same layout and reset as channel A.
      always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
          brk_addr_r[ch]  <= {HALF_RST, HALF_RST};
          addr_mask_r[ch] <= {HALF_RST, HALF_RST};
          cyc_sel_r[ch]   <= CYC_RST;
        end else if (i_clk_en) begin
          if (wr_addr_hi) begin
            brk_addr_r[ch][HI_MSB:HI_LSB] <= i_reg_wdata;
          end
          if (wr_addr_lo) begin
            brk_addr_r[ch][LO_MSB:LO_LSB] <= i_reg_wdata;
          end
          if (wr_mask_hi) begin
            addr_mask_r[ch][HI_MSB:HI_LSB] <= i_reg_wdata;
          end
          if (wr_mask_lo) begin
            addr_mask_r[ch][LO_MSB:LO_LSB] <= i_reg_wdata;
          end
          if (wr_cyc) begin
            // Only the low byte is stored, so the upper byte cannot be set.
            cyc_sel_r[ch] <= i_reg_wdata[CYC_W-1:0];
          end
        end
      end

      chan_if ch_if ();
      assign ch_if.brk_addr   = brk_addr_r[ch];
      assign ch_if.addr_mask  = addr_mask_r[ch];
      assign ch_if.cyc_sel    = cyc_sel_r[ch];
      assign ch_if.ext_en     = ext_en_r;
      assign ch_if.bus_valid  = i_bus_valid;
      assign ch_if.bus_addr   = i_bus_addr;
      assign ch_if.bus_master = i_bus_master;
      assign ch_if.bus_fetch  = i_bus_fetch;
      assign ch_if.bus_write  = i_bus_write;
      assign ch_if.bus_size   = i_bus_size;
      assign match[ch]        = ch_if.match;

      break_channel u_chan (
        .chan (ch_if)
      );
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      ext_en_r   <= 1'b0;
      irq_mask_r <= '0;
    end else if (i_clk_en && i_reg_wr) begin
      if (i_reg_addr == OFS_CTRL) begin
        ext_en_r <= i_reg_wdata[EXT_EN_BIT];
      end else if (i_reg_addr == OFS_IRQ_MASK) begin
        irq_mask_r <= i_reg_wdata[NUM_CH-1:0];
      end
    end
  end

  // Registering the match keeps the long address compare off the status path.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      break_r <= '0;
    end else if (i_clk_en) begin
      break_r <= match;
    end
  end

  always_comb begin
    stat_clr = '0;
    if (i_reg_wr && (i_reg_addr == OFS_IRQ_STAT)) begin
      stat_clr = i_reg_wdata[NUM_CH-1:0];
    end
    // A break in the clearing cycle survives: set wins over clear.
    irq_stat_nxt = (irq_stat_r & ~stat_clr) | break_r;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      irq_stat_r <= '0;
      irq_r      <= 1'b0;
    end else if (i_clk_en) begin
      irq_stat_r <= irq_stat_nxt;
      irq_r      <= |(irq_stat_r & irq_mask_r);
    end
  end

  always_comb begin
    rdata_nxt = '0;
    if (i_reg_rd) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (i_reg_addr == CH_STRIDE * 8'(c) + OFS_ADDR_HI) begin
          rdata_nxt = brk_addr_r[c][HI_MSB:HI_LSB];
        end else if (i_reg_addr == CH_STRIDE * 8'(c) + OFS_ADDR_LO) begin
          rdata_nxt = brk_addr_r[c][LO_MSB:LO_LSB];
        end else if (i_reg_addr == CH_STRIDE * 8'(c) + OFS_MASK_HI) begin
          rdata_nxt = addr_mask_r[c][HI_MSB:HI_LSB];
        end else if (i_reg_addr == CH_STRIDE * 8'(c) + OFS_MASK_LO) begin
          rdata_nxt = addr_mask_r[c][LO_MSB:LO_LSB];
        end else if (i_reg_addr == CH_STRIDE * 8'(c) + OFS_CYC_SEL) begin
          rdata_nxt = {8'h00, cyc_sel_r[c]};
        end
      end
      if (i_reg_addr == OFS_CTRL) begin
        rdata_nxt[EXT_EN_BIT] = ext_en_r;
      end else if (i_reg_addr == OFS_IRQ_STAT) begin
        rdata_nxt[NUM_CH-1:0] = irq_stat_r;
      end else if (i_reg_addr == OFS_IRQ_MASK) begin
        rdata_nxt[NUM_CH-1:0] = irq_mask_r;
      end
    end
  end

  // Read data stand from the enabled edge after the strobe and hold while i_clk_en is low; zero otherwise.
  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rdata_r <= '0;
    end else if (i_clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_break     = break_r;
  assign o_irq       = irq_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  a_mask_excl_bit: assert property (
    (i_clk_en ##1 break_r[0]) |->
      ((($past(i_bus_addr) ^ $past(brk_addr_r[0])) & ~$past(addr_mask_r[0])) == 32'h0))
    else $error("channel A broke on an unmasked address mismatch");

  a_reset_clears: assert property (
    disable iff (1'b0)
    !i_reset_n |=> (addr_mask_r[0] == {HALF_RST, HALF_RST}) && (cyc_sel_r[0] == CYC_RST))
    else $error("reset left channel A mask or cycle select set");

  a_reserved_zero: assert property (
    (i_clk_en && i_reg_rd && (i_reg_addr == OFS_CYC_SEL)) |=> (o_reg_rdata[15:8] == 8'h00))
    else $error("cycle select upper byte read nonzero");

  a_master_off: assert property (
    (i_clk_en && (cyc_sel_r[0][MSEL_HI:MSEL_LO] == 2'b00)) |=> !o_break[0])
    else $error("channel A broke with master field off");

  a_ext_gate: assert property (
    (i_clk_en && (i_bus_master == MASTER_EXT) && !ext_en_r) |=> (o_break == 2'b00))
    else $error("external master cycle broke while not enabled");

  a_kind_off: assert property (
    (i_clk_en && (cyc_sel_r[0][FSEL_HI:FSEL_LO] == 2'b00)) |=> !o_break[0])
    else $error("channel A broke with fetch/access field off");

  a_dir_check: assert property (
    (i_clk_en ##1 o_break[0]) |->
      ($past(i_bus_write) ? $past(cyc_sel_r[0][DSEL_HI]) : $past(cyc_sel_r[0][DSEL_LO])))
    else $error("channel A broke on an unselected direction");

  a_fetch_word: assert property (
    (i_clk_en && i_bus_fetch && (cyc_sel_r[0][SSEL_HI:SSEL_LO] != SIZE_ANY) &&
     (cyc_sel_r[0][SSEL_HI:SSEL_LO] != SIZE_WORD)) |=> !o_break[0])
    else $error("fetch matched a non-word size");

  a_size_source: assert property (
    (i_clk_en ##1 o_break[0]) |->
      (($past(cyc_sel_r[0][SSEL_HI:SSEL_LO]) == SIZE_ANY) || $past(i_bus_fetch) ||
       ($past(cyc_sel_r[0][SSEL_HI:SSEL_LO]) == $past(i_bus_size))))
    else $error("data break ignored operand size");

  a_chan_b_mask: assert property (
    (i_clk_en ##1 o_break[1]) |->
      ((($past(i_bus_addr) ^ $past(brk_addr_r[1])) & ~$past(addr_mask_r[1])) == 32'h0))
    else $error("channel B broke on an unmasked address mismatch");

  a_addr_halves: assert property (
    (i_clk_en && i_reg_wr && (i_reg_addr == OFS_ADDR_HI)) |=>
      ((brk_addr_r[0][HI_MSB:HI_LSB] == $past(i_reg_wdata)) &&
       $stable(brk_addr_r[0][LO_MSB:LO_LSB])))
    else $error("upper address half write went astray");

  a_irq_raise: assert property (
    (o_break[0] && irq_mask_r[0] && i_clk_en && !i_reg_wr) ##1 (i_clk_en && !i_reg_wr)
      |=> o_irq)
    else $error("unmasked break did not raise the interrupt");

  a_valid_needed: assert property (
    (i_clk_en ##1 o_break[0]) |-> $past(i_bus_valid))
    else $error("break without a valid bus cycle");

  // Register halves: a write to one half must leave the other half alone; reset must clear channel B address and mask.
  a_addr_lo_half: assert property (
    (i_clk_en && i_reg_wr && (i_reg_addr == OFS_ADDR_LO)) |=>
      ((brk_addr_r[0][LO_MSB:LO_LSB] == $past(i_reg_wdata)) &&
       $stable(brk_addr_r[0][HI_MSB:HI_LSB])))
    else $error("lower address half write went astray");
  a_mask_hi_half: assert property (
    (i_clk_en && i_reg_wr && (i_reg_addr == OFS_MASK_HI)) |=>
      ((addr_mask_r[0][HI_MSB:HI_LSB] == $past(i_reg_wdata)) &&
       $stable(addr_mask_r[0][LO_MSB:LO_LSB])))
    else $error("upper mask half write went astray");
  a_mask_lo_half: assert property (
    (i_clk_en && i_reg_wr && (i_reg_addr == OFS_MASK_LO)) |=>
      ((addr_mask_r[0][LO_MSB:LO_LSB] == $past(i_reg_wdata)) &&
       $stable(addr_mask_r[0][HI_MSB:HI_LSB])))
    else $error("lower mask half write went astray");
  a_b_reset: assert property (
    disable iff (1'b0)
    !i_reset_n |=> (brk_addr_r[1] == {HALF_RST, HALF_RST}) &&
                   (addr_mask_r[1] == {HALF_RST, HALF_RST}))
    else $error("reset left channel B address or mask set");

  // Qualifier gates: a field that excludes the cycle must keep the pulse low.
  a_cpu_only: assert property (
    (i_clk_en && (cyc_sel_r[0][MSEL_HI:MSEL_LO] == 2'b01) && (i_bus_master != MASTER_CPU))
      |=> !o_break[0])
    else $error("CPU-only channel A broke on a peripheral cycle");
  a_periph_only: assert property (
    (i_clk_en && (cyc_sel_r[0][MSEL_HI:MSEL_LO] == 2'b10) && (i_bus_master == MASTER_CPU))
      |=> !o_break[0])
    else $error("peripheral-only channel A broke on a CPU cycle");
  a_fetch_only: assert property (
    (i_clk_en && (cyc_sel_r[0][FSEL_HI:FSEL_LO] == 2'b01) && !i_bus_fetch) |=> !o_break[0])
    else $error("fetch-only channel A broke on a data access");
  a_data_only: assert property (
    (i_clk_en && (cyc_sel_r[0][FSEL_HI:FSEL_LO] == 2'b10) && i_bus_fetch) |=> !o_break[0])
    else $error("data-only channel A broke on a fetch");
  a_dir_off: assert property (
    (i_clk_en && (cyc_sel_r[0][DSEL_HI:DSEL_LO] == 2'b00)) |=> !o_break[0])
    else $error("channel A broke with direction field off");
  a_data_size: assert property (
    (i_clk_en && !i_bus_fetch && (cyc_sel_r[0][SSEL_HI:SSEL_LO] != SIZE_ANY) &&
     (cyc_sel_r[0][SSEL_HI:SSEL_LO] != i_bus_size)) |=> !o_break[0])
    else $error("data access matched another operand size");

  // With every address bit masked, a channel whose fields select the cycle must break.
  a_dma_eligible: assert property (
    (i_clk_en && i_bus_valid && (i_bus_master == MASTER_DMA) && (cyc_sel_r[0] == 8'hBC) &&
     (addr_mask_r[0] == 32'hFFFF_FFFF)) |=> o_break[0])
    else $error("DMA cycle missed with peripheral cycles selected");
  a_ext_eligible: assert property (
    (i_clk_en && i_bus_valid && (i_bus_master == MASTER_EXT) && ext_en_r &&
     (cyc_sel_r[0] == 8'hBC) && (addr_mask_r[0] == 32'hFFFF_FFFF)) |=> o_break[0])
    else $error("enabled external master cycle missed");
  a_size_ignored: assert property (
    (i_clk_en && i_bus_valid && (i_bus_master != MASTER_EXT) && (cyc_sel_r[0] == 8'hFC) &&
     (addr_mask_r[0] == 32'hFFFF_FFFF)) |=> o_break[0])
    else $error("fully enabled channel A missed a cycle");

  // Interrupt status: set on every pulse, cleared by a one, quiet when masked.
  a_status_set: assert property (
    (i_clk_en && o_break[0]) |=> irq_stat_r[0])
    else $error("break pulse did not set the status bit");
  a_status_clear: assert property (
    (i_clk_en && i_reg_wr && (i_reg_addr == OFS_IRQ_STAT) && i_reg_wdata[0] && !break_r[0])
      |=> !irq_stat_r[0])
    else $error("status bit survived its clear");
  a_irq_quiet: assert property (
    (i_clk_en && ((irq_stat_r & irq_mask_r) == '0)) |=> !o_irq)
    else $error("interrupt raised with no unmasked status bit");

  c_break_a: cover property (i_clk_en && match[0]);
  c_break_b: cover property (i_clk_en && match[1]);
  c_ext_break: cover property (i_clk_en && match[0] && (i_bus_master == MASTER_EXT));
  c_fetch_word: cover property (i_clk_en && match[0] && i_bus_fetch);
  c_irq_clear: cover property (o_irq ##1 (i_reg_wr && (i_reg_addr == OFS_IRQ_STAT)));
endmodule : break_condition_matcher

// ### sim/bus_cycle_source.sv
// Purpose: Stands in for the CPU, on-chip DMA and external masters on the watched bus.
// Assumes: The bench raises i_req for one cycle per bus cycle it wants issued.
// Notes:   Between cycles the address, fetch, write and size fields are scrambled, so a stale value can never match.
`timescale 1ns/1ps
module bus_cycle_source (
  input  wire logic               i_clk_sys,
  input  wire logic               i_req,
  input  wire logic [31:0]        i_addr,
  input  wire break_pkg::master_t i_master,
  input  wire logic               i_fetch,
  input  wire logic               i_write,
  input  wire break_pkg::size_t   i_size,
  output logic                    o_valid,
  output logic [31:0]             o_addr,
  output break_pkg::master_t      o_master,
  output logic                    o_fetch,
  output logic                    o_write,
  output break_pkg::size_t        o_size
);
  import break_pkg::*;
  initial begin
    o_valid  = 1'b0;
    o_addr   = 32'h0000_0000;
    o_master = MASTER_CPU;
    o_fetch  = 1'b0;
    o_write  = 1'b0;
    o_size   = SIZE_ANY;
  end
  always @(posedge i_clk_sys) begin
    o_valid <= i_req;
    if (i_req) begin
      o_addr   <= i_addr;
      o_master <= i_master;
      o_fetch  <= i_fetch;
      o_write  <= i_write;
      // A fetch is always a longword on the bus, whatever the instruction size.
      o_size   <= i_fetch ? SIZE_LONG : i_size;
    end else begin
      o_addr   <= ~o_addr;
      o_fetch  <= ~o_fetch;
      o_write  <= ~o_write;
      o_size   <= size_t'(~o_size);
    end
  end
endmodule : bus_cycle_source

// ### sim/break_condition_matcher_bench.sv
// Purpose: Self-checking bench for the break condition matcher.
// Assumes: Register offsets and field layout as in the package.
// Notes:   Channel B is idled while the qualifier sweep runs on channel A.
`timescale 1ns/1ps
module break_condition_matcher_bench;
  import break_pkg::*;
  logic        clk_sys   = 1'b0;
  logic        reset_n   = 1'b0;
  logic        clk_en    = 1'b1;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        req       = 1'b0;
  logic [31:0] addr      = 32'h0000_0000;
  master_t     master    = MASTER_CPU;
  logic        fetch     = 1'b0;
  logic        write     = 1'b0;
  size_t       size      = SIZE_BYTE;
  logic        bus_valid, bus_fetch, bus_write, irq;
  logic [31:0] bus_addr;
  master_t     bus_master;
  size_t       bus_size;
  logic [1:0]  brk;
  logic [7:0]  sel;
  int          fails     = 0;
  int          n_tests   = 0;
  int          cyc_cnt   = 0;

  always #2.5 clk_sys = ~clk_sys;

  break_condition_matcher i_dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_clk_en(clk_en),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .o_reg_rdata(reg_rdata), .i_bus_valid(bus_valid), .i_bus_addr(bus_addr),
    .i_bus_master(bus_master), .i_bus_fetch(bus_fetch), .i_bus_write(bus_write),
    .i_bus_size(bus_size), .o_break(brk), .o_irq(irq));

  bus_cycle_source i_src (.i_clk_sys(clk_sys), .i_req(req), .i_addr(addr),
    .i_master(master), .i_fetch(fetch), .i_write(write), .i_size(size),
    .o_valid(bus_valid), .o_addr(bus_addr), .o_master(bus_master), .o_fetch(bus_fetch),
    .o_write(bus_write), .o_size(bus_size));

  task final_report;
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 check({16'h0000, reg_rdata}, {16'h0000, exp}, "register read");
  endtask : rd_chk

  // Issues one bus cycle and looks at the break pulse in the one cycle it stands.
  task bus(input logic [31:0] a, input int m, input logic f, input logic w, input int sz,
           input logic [1:0] exp);
    @(posedge clk_sys);
    req    <= 1'b1;
    addr   <= a;
    master <= master_t'(m[1:0]);
    fetch  <= f;
    write  <= w;
    size   <= size_t'(sz[1:0]);
    @(posedge clk_sys);
    req    <= 1'b0;
    @(posedge clk_sys);
    #1 check({30'h0, brk}, {30'h0, exp}, "break pulse");
  endtask : bus

  function automatic logic exp_match(input logic [7:0] s, input int m, input logic f,
                                     input logic w, input int sz);
    logic mo;
    int   esz;
    mo  = (m == 0) ? s[6] : (s[7] & ((m == 1) | (^s)));
    esz = f ? 2 : sz;
    return mo & (f ? s[4] : s[5]) & (w ? s[3] : s[2])
           & ((s[1:0] == 2'h0) || (int'(s[1:0]) == esz));
  endfunction : exp_match

  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 50000) begin
      fails++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      rd_chk(8'(i), 16'h0000);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'(i), 16'hA5C3 ^ 16'(i));
      wr(CH_STRIDE + 8'(i), 16'h3C5A ^ 16'(i));
      rd_chk(8'(i), 16'hA5C3 ^ 16'(i));
      rd_chk(CH_STRIDE + 8'(i), 16'h3C5A ^ 16'(i));
    end
    wr(OFS_CYC_SEL, 16'hFFFF);
    rd_chk(OFS_CYC_SEL, 16'h00FF);
    wr(8'h1F, 16'hFFFF);
    rd_chk(8'h1F, 16'h0000);
    wr(OFS_ADDR_HI, 16'h1234);
    wr(OFS_ADDR_LO, 16'h5678);
    wr(OFS_MASK_HI, 16'h8000);
    wr(OFS_MASK_LO, 16'h0001);
    wr(OFS_CYC_SEL, 16'h00FC);
    wr(CH_STRIDE + OFS_ADDR_HI, 16'hCAFE);
    wr(CH_STRIDE + OFS_MASK_LO, 16'hFFFF);
    wr(CH_STRIDE + OFS_MASK_HI, 16'h0000);
    bus(32'h9234_5679, 0, 1'b0, 1'b0, 1, 2'b01);
    bus(32'h1235_5678, 0, 1'b0, 1'b0, 1, 2'b00);
    bus(32'h1234_5478, 0, 1'b0, 1'b0, 1, 2'b00);
    wr(CH_STRIDE + OFS_CYC_SEL, 16'h00FC);
    bus(32'hCAFE_1234, 1, 1'b0, 1'b1, 3, 2'b10);
    wr(CH_STRIDE + OFS_CYC_SEL, 16'h0000);
    rd_chk(OFS_IRQ_STAT, 16'h0003);
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(OFS_IRQ_MASK, 16'h0001);
    @(posedge clk_sys);
    #1 check({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(OFS_IRQ_MASK, 16'h0001);
    wr(OFS_IRQ_STAT, 16'h0001);
    @(posedge clk_sys);
    #1 check({31'h0, irq}, 32'h0, "irq cleared");
    rd_chk(OFS_IRQ_STAT, 16'h0002);
    // A write while the clock enable is low must not land.
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(OFS_ADDR_HI, 16'hBEEF);
    clk_en <= 1'b1;
    rd_chk(OFS_ADDR_HI, 16'h1234);
    wr(OFS_MASK_HI, 16'hFFFF);
    wr(OFS_MASK_LO, 16'hFFFF);
    for (int s = 0; s < 256; s++) begin
      sel = 8'(s);
      // Fetch breaks are never programmed with the low size bit set.
      if (sel[4] && sel[0])
        continue;
      wr(OFS_CYC_SEL, {8'h00, sel});
      wr(OFS_CTRL, {15'h0, ^sel});
      rd_chk(OFS_CTRL, {15'h0, ^sel});
      for (int m = 0; m < 3; m++)
        for (int f = 0; f < 2; f++)
          for (int w = 0; w < 2; w++)
            for (int z = 1; z < 4; z++)
              bus(32'h0F0F_0000 + 32'(s), m, f[0], w[0], z,
                  {1'b0, exp_match(sel, m, f[0], w[0], z)});
    end
    // A second reset in mid-run must clear what the sweep left behind.
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    #1 check({31'h0, irq}, 32'h0, "irq after reset");
    rd_chk(OFS_MASK_HI, 16'h0000);
    rd_chk(OFS_MASK_LO, 16'h0000);
    rd_chk(OFS_CYC_SEL, 16'h0000);
    rd_chk(CH_STRIDE + OFS_MASK_LO, 16'h0000);
    rd_chk(OFS_CTRL, 16'h0000);
    rd_chk(OFS_IRQ_STAT, 16'h0000);
    final_report();
  end
endmodule : break_condition_matcher_bench
